// ==== hdl/osc_ctrl.sv ====
// Oscillator clock source control with AXI4-Lite registers
//
// Operation
// - Active source oscillator enabled only while the mode logic enable is high.
// - Crystal clock sampled safely; odd duty cycle and startup jitter tolerated.
// - x4 output follows the currently selected source clock.
// - x2 output toggles on each x4 rising edge, half its rate.
// - Wait mode does not alter the oscillator logic; clocks keep running.
// - Stop mode (enable low) halts the source clock and both outputs.
// - Debug break leaves both clock outputs running.
// - Two-bit select picks internal, external clock, RC or crystal.
// - Request bit enables external generator and starts the switch.
// - Reset clears the request bit.
// - Request bit ignored in monitor mode with internal oscillator bypassed; code blocks only the switch, RC and crystal enables still follow it.
// - Engaged bit reads 1 while an external source drives the clock.
// - Eight-bit trim factor steers internal oscillator period.
// - Trim factor resets to its midpoint value.
// - Two external rising edges, glitch-free swap, engaged set, then internal stopped.
// - Internal oscillator restarts only on reset; no automatic fallback.
// - Pin two drives x4 when enabled in internal or RC mode, is released (output off, low) in crystal mode, else I/O.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module osc_ctrl
  import osc_pkg::*;
#(
  parameter int EDGE_COUNT = EDGES_TO_SWITCH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode logic side
  input wire logic oscillator_enable_in,
  input wire logic monitor_bypass,
  output logic clock_x4_out,
  output logic clock_x2_out,
  // Raw source clocks from the oscillator circuits and pin one
  input wire logic internal_osc_clock,
  input wire logic resistor_cap_clock,
  input wire logic crystal_clock,
  input wire logic ext_pin_clock,
  // Oscillator circuit enables and trim
  output logic internal_osc_en,
  output logic rc_osc_en,
  output logic crystal_osc_en,
  output logic [7:0] trim_factor,
  // Pin two and its port logic
  input wire logic port_pin_two_o,
  input wire logic port_pin_two_oe,
  output logic pin_two_o,
  output logic pin_two_oe,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (EDGE_COUNT < 1 || EDGE_COUNT > 7) begin : g_chk
    $error("EDGE_COUNT must lie in 1..7");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] int_s1;
    logic [1:0] rc_s;
    logic [1:0] xt_s;
    logic [1:0] pin_s;
    logic [1:0] mon_s;
    logic ext_prev;
    logic x4;
    logic x2;
    logic req;
    logic engaged;
    logic use_ext;
    logic int_stop;
    logic [7:0] trim;
    logic [1:0] srcsel;
    logic p2en;
    logic [1:0] ists;
    logic [1:0] ien;
    logic irq;
    osc_state_e st;
    logic [2:0] edges;
    logic int_en;
    logic rc_en;
    logic xt_en;
    logic p2o;
    logic p2oe;
  } osc_state_s;

  osc_state_s s_q;
  osc_state_s s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Synchronised level of the external source chosen by the select
  function automatic logic ext_level(input logic [1:0] sel,
                                     input logic pin_l,
                                     input logic rc_l,
                                     input logic xt_l);
    logic l;
    l = 1'b0;
    case (sel)
      SRC_EXT_CLOCK: l = pin_l;
      SRC_RC: l = rc_l;
      SRC_CRYSTAL: l = xt_l;
      default: l = 1'b0;
    endcase
    return l;
  endfunction

  // Register read mux
  function automatic logic [31:0] reg_read(input osc_state_s s,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      OSC_STATUS_OFS: begin
        v[REQ_BIT] = s.req;
        v[ENG_BIT] = s.engaged;
      end
      OSC_TRIM_OFS: v[7:0] = s.trim;
      OSC_CONFIG_OFS: begin
        v[SEL_LSB +: 2] = s.srcsel;
        v[P2EN_BIT] = s.p2en;
      end
      OSC_ISTS_OFS: v[1:0] = s.ists;
      OSC_IEN_OFS: v[1:0] = s.ien;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OSC_STATUS_OFS) || (a == OSC_TRIM_OFS) ||
           (a == OSC_CONFIG_OFS) || (a == OSC_ISTS_OFS) ||
           (a == OSC_ICLR_OFS) || (a == OSC_IEN_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ext_l;
    logic int_l;
    logic src_l;
    logic ext_rise;
    logic bypass;
    logic wr_go;
    logic ev_done;
    logic ev_ign;
    logic [1:0] clr;
    ext_l = 1'b0;
    int_l = 1'b0;
    src_l = 1'b0;
    ext_rise = 1'b0;
    bypass = 1'b0;
    wr_go = 1'b0;
    ev_done = 1'b0;
    ev_ign = 1'b0;
    clr = 2'h0;
    s_d = s_q;

    // Two-stage synchronisers; only the second stage is read
    s_d.int_s1 = {s_q.int_s1[0], internal_osc_clock};
    s_d.rc_s = {s_q.rc_s[0], resistor_cap_clock};
    s_d.xt_s = {s_q.xt_s[0], crystal_clock};
    s_d.pin_s = {s_q.pin_s[0], ext_pin_clock};
    s_d.mon_s = {s_q.mon_s[0], monitor_bypass};
    int_l = s_q.int_s1[1];
    bypass = s_q.mon_s[1];
    ext_l = ext_level(s_q.srcsel, s_q.pin_s[1], s_q.rc_s[1], s_q.xt_s[1]);
    // Edge detect on the synced level tolerates any duty cycle
    ext_rise = ext_l && !s_q.ext_prev;
    s_d.ext_prev = ext_l;

    // Clock outputs; wait and break leave them running
    src_l = s_q.use_ext ? ext_l : int_l;
    if (oscillator_enable_in) begin
      s_d.x4 = src_l;
      if (src_l && !s_q.x4) begin
        s_d.x2 = !s_q.x2;
      end
    end else begin
      s_d.x4 = 1'b0;
      s_d.x2 = 1'b0;
    end

    // Switch sequence
    case (s_q.st)
      ST_INT: begin
        s_d.edges = 3'h0;
        if (s_q.req && !bypass && s_q.srcsel != SRC_INTERNAL) begin
          s_d.st = ST_WAIT;
        end
        ev_ign = s_q.req && bypass;
      end
      ST_WAIT: begin
        if (!s_q.req || bypass) begin
          s_d.st = ST_INT;
        end else if (ext_rise) begin
          s_d.edges = s_q.edges + 3'h1;
          if (s_q.edges == 3'(EDGE_COUNT - 1)) begin
            s_d.st = ST_SWAP;
          end
        end
      end
      ST_SWAP: begin
        // Swap only while both clocks sit low: no short pulse
        if (!ext_l && !int_l) begin
          s_d.use_ext = 1'b1;
          s_d.engaged = 1'b1;
          s_d.st = ST_STOPINT;
          ev_done = 1'b1;
        end
      end
      ST_STOPINT: begin
        s_d.int_stop = 1'b1;
        s_d.st = ST_EXT;
      end
      ST_EXT: begin
        // Held until reset; no fallback on a dead clock
        s_d.st = ST_EXT;
      end
      default: s_d.st = ST_INT;
    endcase

    // Oscillator circuit enables
    s_d.int_en = oscillator_enable_in && !s_q.int_stop;
    s_d.rc_en = oscillator_enable_in && (s_q.req || s_q.engaged) &&
                (s_q.srcsel == SRC_RC);
    s_d.xt_en = oscillator_enable_in && (s_q.req || s_q.engaged) &&
                (s_q.srcsel == SRC_CRYSTAL);

    // Pin two function
    if ((s_q.srcsel == SRC_INTERNAL || s_q.srcsel == SRC_RC) && s_q.p2en) begin
      s_d.p2o = s_d.x4;
      s_d.p2oe = 1'b1;
    end else if (s_q.srcsel == SRC_CRYSTAL) begin
      s_d.p2o = 1'b0;
      s_d.p2oe = 1'b0;
    end else begin
      s_d.p2o = port_pin_two_o;
      s_d.p2oe = port_pin_two_oe;
    end

    // AXI write channel capture
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.awready = 1'b0;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.wready = 1'b0;
      s_d.wbyte = s_axi_wdata[7:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wlane0) begin
        case (s_q.awaddr)
          OSC_STATUS_OFS: s_d.req = s_q.wbyte[REQ_BIT];
          OSC_TRIM_OFS: s_d.trim = s_q.wbyte;
          OSC_CONFIG_OFS: begin
            s_d.srcsel = s_q.wbyte[SEL_LSB +: 2];
            s_d.p2en = s_q.wbyte[P2EN_BIT];
          end
          OSC_ICLR_OFS: clr = s_q.wbyte[1:0];
          OSC_IEN_OFS: s_d.ien = s_q.wbyte[1:0];
          default: s_d.req = s_q.req;
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // AXI read channel
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = reg_read(s_q, s_axi_araddr);
      s_d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Sticky events; a set in the clear cycle wins
    s_d.ists = (s_q.ists & ~clr) |
               {ev_ign, 1'b0} | {1'b0, ev_done};
    s_d.irq = |(s_d.ists & s_q.ien);

    // Synchronous reset
    if (!aresetn) begin
      s_d = '0;
      s_d.st = ST_INT;
      s_d.req = 1'b0;
      s_d.engaged = 1'b0;
      s_d.trim = TRIM_RESET;
      s_d.srcsel = SEL_RESET;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign clock_x4_out = s_q.x4;
  assign clock_x2_out = s_q.x2;
  assign internal_osc_en = s_q.int_en;
  assign rc_osc_en = s_q.rc_en;
  assign crystal_osc_en = s_q.xt_en;
  assign trim_factor = s_q.trim;
  assign pin_two_o = s_q.p2o;
  assign pin_two_oe = s_q.p2oe;
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// ==== hdl/osc_pkg.sv ====
// Constants and types of the oscillator clock source control
`default_nettype none
package osc_pkg;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OSC_STATUS_OFS = 8'h00;
  localparam logic [7:0] OSC_TRIM_OFS = 8'h04;
  localparam logic [7:0] OSC_CONFIG_OFS = 8'h08;
  localparam logic [7:0] OSC_ISTS_OFS = 8'h0c;
  localparam logic [7:0] OSC_ICLR_OFS = 8'h10;
  localparam logic [7:0] OSC_IEN_OFS = 8'h14;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int REQ_BIT = 0;
  localparam int ENG_BIT = 1;
  localparam int SEL_LSB = 0;
  localparam int P2EN_BIT = 7;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_IGN_BIT = 1;

  // --------------------------------------------------------------
  // Reset values and counts
  // --------------------------------------------------------------
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam int EDGES_TO_SWITCH = 2;

  // --------------------------------------------------------------
  // Source encodings
  // --------------------------------------------------------------
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXT_CLOCK = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  localparam logic [1:0] SRC_CRYSTAL = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Switch sequence states
  typedef enum logic [2:0] {
    ST_INT, ST_WAIT, ST_SWAP, ST_STOPINT, ST_EXT
  } osc_state_e;

endpackage
`default_nettype wire

// ==== tb/osc_ctrl_sva.sv ====
// Concurrent checks on the oscillator control ports
`default_nettype none
module osc_ctrl_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Clock outputs and oscillator enables
  input wire logic oscillator_enable_in,
  input wire logic clock_x4_out,
  input wire logic clock_x2_out,
  input wire logic internal_osc_en,
  input wire logic rc_osc_en,
  input wire logic crystal_osc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Stop mode silences both clock outputs
  a_stop_clocks_low: assert property (
    !oscillator_enable_in |=> !clock_x4_out && !clock_x2_out) else $error("clock out in stop");
  // Stop mode disables every oscillator
  a_stop_osc_off: assert property (
    !oscillator_enable_in |=> !internal_osc_en && !rc_osc_en && !crystal_osc_en)
    else $error("oscillator on in stop");
  // Half rate output rises only around a fast rise
  a_x2_follows_x4: assert property (
    $rose(clock_x2_out) |-> clock_x4_out || $past(clock_x4_out)) else $error("x2 rose alone");
  // Write answered two cycles after capture
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  // Read answered one cycle after capture
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  // No new write while a response waits
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  // No new read while data waits
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // Response drops after its handshake
  a_resp_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
endmodule

bind osc_ctrl osc_ctrl_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .oscillator_enable_in, .clock_x4_out, .clock_x2_out,
  .internal_osc_en, .rc_osc_en, .crystal_osc_en);
`default_nettype wire

// ==== tb/osc_far_model.sv ====
// Far-side model: mode enable and raw oscillator clocks
`default_nettype none
module osc_far_model (
  // Bench controls
  input wire logic stop_req,
  input wire logic ext_run,
  // Oscillator enables from the block
  input wire logic internal_osc_en,
  input wire logic rc_osc_en,
  input wire logic crystal_osc_en,
  // Mode enable and raw clocks
  output logic oscillator_enable_in,
  output logic internal_osc_clock,
  output logic resistor_cap_clock,
  output logic crystal_clock,
  output logic ext_pin_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // Stop mode drops the enable
  assign oscillator_enable_in = !stop_req;

  // Each oscillator idles low while disabled
  always begin
    #100;
    internal_osc_clock = internal_osc_en && (internal_osc_clock !== 1'b1);
  end
  always begin
    #125;
    resistor_cap_clock = rc_osc_en && (resistor_cap_clock !== 1'b1);
  end
  always begin
    #175;
    crystal_clock = crystal_osc_en && (crystal_clock !== 1'b1);
  end
  always begin
    #150;
    ext_pin_clock = ext_run && (ext_pin_clock !== 1'b1);
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the oscillator control
`default_nettype none
module testbench
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, trim_factor;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic oscillator_enable_in, monitor_bypass, clock_x4_out, clock_x2_out, irq;
  logic internal_osc_clock, resistor_cap_clock, crystal_clock, ext_pin_clock;
  logic internal_osc_en, rc_osc_en, crystal_osc_en, port_pin_two_o, port_pin_two_oe;
  logic pin_two_o, pin_two_oe, stop_req, ext_run;
  int errors, cmp_count;

  osc_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .oscillator_enable_in, .monitor_bypass, .clock_x4_out, .clock_x2_out,
    .internal_osc_clock, .resistor_cap_clock, .crystal_clock, .ext_pin_clock,
    .internal_osc_en, .rc_osc_en, .crystal_osc_en, .trim_factor, .port_pin_two_o,
    .port_pin_two_oe, .pin_two_o, .pin_two_oe, .irq);
  osc_far_model i_far (.stop_req, .ext_run, .internal_osc_en, .rc_osc_en, .crystal_osc_en,
    .oscillator_enable_in, .internal_osc_clock, .resistor_cap_clock, .crystal_clock,
    .ext_pin_clock);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (n < 40 && !(!aw && !w && s_axi_bvalid)) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    hang(n);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  // Bus read returning data and response
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    int n;
    ar = 1'b1;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (n < 40 && !(!ar && s_axi_rvalid)) begin
      @(posedge aclk);
      n++;
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    hang(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er,
                      input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, {24'h0, e}, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  // Poll status until the switch reports engaged
  task automatic wait_engaged();
    logic [31:0] v;
    logic [1:0] r;
    v = 32'h0;
    for (int k = 0; k < 30 && v[ENG_BIT] !== 1'b1; k++) rd(OSC_STATUS_OFS, v, r);
    chk("status", 32'h3, v);
    if (v[ENG_BIT] !== 1'b1) hang(40);
  endtask

  // Count rises of both clock outputs
  task automatic clkchk(input int cyc, input int lo, input int hi);
    logic p4, p2;
    int c4, c2;
    c4 = 0;
    c2 = 0;
    p4 = clock_x4_out;
    p2 = clock_x2_out;
    repeat (cyc) begin
      @(posedge aclk);
      if (clock_x4_out && !p4) c4++;
      if (clock_x2_out && !p2) c2++;
      p4 = clock_x4_out;
      p2 = clock_x2_out;
    end
    chk("x4 rises", 32'h1, 32'(c4 >= lo && c4 <= hi));
    chk("x2 rises", 32'h1, 32'(c2 * 2 >= c4 - 2 && c2 * 2 <= c4 + 2));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rchk(OSC_STATUS_OFS, 8'h00, RESP_OKAY, "status");
    rchk(OSC_TRIM_OFS, TRIM_RESET, RESP_OKAY, "trim");
  endtask

  task automatic t_trim();
    wr(OSC_TRIM_OFS, 8'h5a, RESP_OKAY);
    rchk(OSC_TRIM_OFS, 8'h5a, RESP_OKAY, "trim");
    chk("trim port", 32'h5a, 32'(trim_factor));
    s_axi_wstrb <= 4'he;
    wr(OSC_TRIM_OFS, 8'h11, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rchk(OSC_TRIM_OFS, 8'h5a, RESP_OKAY, "trim masked");
    rchk(8'h18, 8'h00, RESP_SLVERR, "unmapped");
    wr(8'h1c, 8'hff, RESP_SLVERR);
  endtask

  task automatic t_stop();
    clkchk(160, 19, 21);
    stop_req <= 1'b1;
    repeat (4) @(posedge aclk);
    clkchk(40, 0, 0);
    chk("int osc en", 32'h0, 32'(internal_osc_en));
    stop_req <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("int osc en", 32'h1, 32'(internal_osc_en));
  endtask

  task automatic t_pin_two();
    port_pin_two_o <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(OSC_CONFIG_OFS, 8'h80 | 8'(i), RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("pin oe", 32'(~i & 1), 32'(pin_two_oe));
      if (i != 3) chk("pin out", (i == 1) ? 32'h1 : 32'(clock_x4_out), 32'(pin_two_o));
    end
  endtask

  task automatic t_bypass();
    monitor_bypass <= 1'b1;
    wr(OSC_CONFIG_OFS, 8'h01, RESP_OKAY);
    wr(OSC_IEN_OFS, 8'h02, RESP_OKAY);
    wr(OSC_STATUS_OFS, 8'h01, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rchk(OSC_STATUS_OFS, 8'h01, RESP_OKAY, "status");
    rchk(OSC_ISTS_OFS, 8'h02, RESP_OKAY, "events");
    chk("irq", 32'h1, 32'(irq));
    wr(OSC_STATUS_OFS, 8'h00, RESP_OKAY);
    wr(OSC_ICLR_OFS, 8'h02, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    monitor_bypass <= 1'b0;
  endtask

  task automatic t_switch();
    wr(OSC_CONFIG_OFS, {6'h0, SRC_EXT_CLOCK}, RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(OSC_IEN_OFS, 8'h01, RESP_OKAY);
    wr(OSC_STATUS_OFS, 8'h01, RESP_OKAY);
    wait_engaged();
    chk("irq", 32'h1, 32'(irq));
    repeat (3) @(posedge aclk);
    chk("int osc en", 32'h0, 32'(internal_osc_en));
    clkchk(168, 13, 15);
    wr(OSC_IEN_OFS, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OSC_ICLR_OFS, 8'h01, RESP_OKAY);
    ext_run <= 1'b0;
    wr(OSC_STATUS_OFS, 8'h00, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rchk(OSC_STATUS_OFS, 8'h02, RESP_OKAY, "status");
    chk("int osc en", 32'h0, 32'(internal_osc_en));
  endtask

  task automatic t_rereset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    repeat (3) @(posedge aclk);
    chk("int osc en", 32'h1, 32'(internal_osc_en));
  endtask

  task automatic t_rc_switch();
    wr(OSC_CONFIG_OFS, {6'h0, SRC_RC}, RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(OSC_STATUS_OFS, 8'h01, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("rc osc en", 32'h1, 32'(rc_osc_en));
    chk("xtal osc en", 32'h0, 32'(crystal_osc_en));
    wait_engaged();
    clkchk(150, 14, 16);
  endtask

  // Main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, monitor_bypass, stop_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {port_pin_two_o, port_pin_two_oe} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    ext_run = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_trim();
    t_stop();
    t_pin_two();
    t_bypass();
    t_switch();
    t_rereset();
    t_rc_switch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
